// >>> verilog/emt_params.svh
`ifndef EMT_PARAMS_SVH
`define EMT_PARAMS_SVH

// core clock and basic clock rates, in Hz
`define EMT_CLK_HZ 10000000
`define EMT_SLOW_HZ_100K 100000
`define EMT_SLOW_HZ_10K 10000
`define EMT_SLOW_HZ_2K 2000
`define EMT_SLOW_HZ_1K 1000
`define EMT_FAST_HZ_HI 1125000
`define EMT_FAST_HZ_LO 112500

// register addresses
`define EMT_ADDR_LIMIT 8'h1e
`define EMT_ADDR_COUNT 8'h1f
`define EMT_ADDR_FAST_LIMIT 8'h20
`define EMT_ADDR_FAST_CTRL 8'h28
`define EMT_ADDR_SLOW_CTRL 8'h29
`define EMT_ADDR_FAST_CLK 8'h2a

// field positions
`define EMT_SLOW_RUN_BIT 3
`define EMT_SLOW_CLR_BIT 2
`define EMT_SLOW_SEL_HI_BIT 1
`define EMT_SLOW_SEL_LO_BIT 0
`define EMT_FAST_MODE_BIT 3
`define EMT_FAST_RUN_BIT 1
`define EMT_FAST_CLR_BIT 0
`define EMT_FAST_CLK_BIT 0

// reset values
`define EMT_LIMIT_RESET 8'hff
`define EMT_COUNT_RESET 8'h00

`endif

// >>> verilog/emt_pkg.sv
package emt_pkg;

  // one access through the transfer buffer
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } emt_req_t;

endpackage

// >>> verilog/emt_counter.sv
`timescale 1ns/1ps
`include "emt_params.svh"

module emt_counter
  import emt_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic hard_clear,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic [WIDTH-1:0] limit,
  // state
  output logic [WIDTH-1:0] count,
  output logic match
);

  logic [WIDTH-1:0] next_count;

  assign next_count = count + WIDTH'(1);

  always_ff @(posedge clk)
  begin
    if (!rstn || hard_clear)
    begin
      count <= '0;
      match <= 1'b0;
    end
    else if (clear)
    begin
      count <= '0;
      match <= 1'b0;
    end
    else if (step)
    begin
      if (next_count == limit)
      begin
        count <= '0;
        match <= 1'b1;
      end
      else
      begin
        count <= next_count;
        match <= 1'b0;
      end
    end
    else
    begin
      match <= 1'b0;
    end
  end

endmodule

// >>> verilog/emt_timers.sv
// How it works
// - slow count clears on resets, on the clear bit and on a match
// - slow limit sets all ones, also on CE
// - interrupt period is basic clock times limit
// - run gating errs at most one count
// - clear errs by up to one tick
// - clock change errs up to one new period
// - interrupt may coincide with CE reset
// - fast timer counts 1.25 MHz or 10 MHz/88 (integer divisors 8 and 88)
// - fast mode puts converter pins in port mode
// - fast mode forces eight-bit converter counter
// - fast clock select bit 0 picks rate
// - control bit 3 picks timer or converter
// - control bit 1 starts and stops
// - control bit 0 clears fast counter
// - match raises interrupt and clears count
// - two-bit select gives 100k/10k/2k/1k
// - clear bit writes one, reads zero
// - slow control bit 3 starts and stops
`timescale 1ns/1ps
`include "emt_params.svh"

module emt_timers
  import emt_pkg::*;
#(
  parameter int SLOW_DIV_100K = `EMT_CLK_HZ / `EMT_SLOW_HZ_100K,
  parameter int SLOW_DIV_10K = `EMT_CLK_HZ / `EMT_SLOW_HZ_10K,
  parameter int SLOW_DIV_2K = `EMT_CLK_HZ / `EMT_SLOW_HZ_2K,
  parameter int SLOW_DIV_1K = `EMT_CLK_HZ / `EMT_SLOW_HZ_1K,
  parameter int FAST_DIV_HI = `EMT_CLK_HZ / `EMT_FAST_HZ_HI,
  parameter int FAST_DIV_LO = `EMT_CLK_HZ / `EMT_FAST_HZ_LO
)
(
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic watchdog_stack_reset,
  input wire logic clock_stop,
  // transfer buffer access
  input wire emt_req_t req,
  output logic [7:0] rdata,
  // events
  output logic slow_irq,
  output logic fast_irq,
  // converter steering
  output logic dac_port_mode,
  output logic dac_force_8bit
);

  logic hard_clear;
  logic slow_timer_run;
  logic [1:0] slow_sel;
  logic [1:0] slow_sel_d;
  logic [7:0] interval_limit;
  logic fast_timer_mode_select;
  logic fast_timer_run;
  logic fast_clock_select;
  logic fast_clock_select_d;
  logic [7:0] fast_limit;
  logic slow_timer_clear;
  logic fast_timer_clear;
  logic [13:0] slow_pre;
  logic [13:0] slow_div;
  logic slow_tick;
  logic [6:0] fast_pre;
  logic [6:0] fast_div;
  logic fast_tick;
  logic [7:0] interval_count;
  logic [7:0] fast_count;

  assign hard_clear = watchdog_stack_reset || clock_stop;

  // write-one clear strobes
  assign slow_timer_clear = req.wr && (req.addr == `EMT_ADDR_SLOW_CTRL)
    && req.wdata[`EMT_SLOW_CLR_BIT];
  assign fast_timer_clear = req.wr && (req.addr == `EMT_ADDR_FAST_CTRL)
    && req.wdata[`EMT_FAST_CLR_BIT];

  // control and limit registers
  always_ff @(posedge clk)
  begin
    if (!rstn || hard_clear)
    begin
      slow_timer_run <= 1'b0;
      slow_sel <= 2'h0;
      interval_limit <= `EMT_LIMIT_RESET;
      fast_timer_mode_select <= 1'b0;
      fast_timer_run <= 1'b0;
      fast_clock_select <= 1'b0;
      fast_limit <= `EMT_LIMIT_RESET;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        `EMT_ADDR_LIMIT: interval_limit <= req.wdata;
        `EMT_ADDR_FAST_LIMIT: fast_limit <= req.wdata;
        `EMT_ADDR_SLOW_CTRL:
        begin
          slow_timer_run <= req.wdata[`EMT_SLOW_RUN_BIT];
          slow_sel <= {req.wdata[`EMT_SLOW_SEL_HI_BIT], req.wdata[`EMT_SLOW_SEL_LO_BIT]};
        end
        `EMT_ADDR_FAST_CTRL:
        begin
          fast_timer_mode_select <= req.wdata[`EMT_FAST_MODE_BIT];
          fast_timer_run <= req.wdata[`EMT_FAST_RUN_BIT];
        end
        `EMT_ADDR_FAST_CLK: fast_clock_select <= req.wdata[`EMT_FAST_CLK_BIT];
        default:
        begin
        end
      endcase
    end
  end

  // basic clock divisors
  always_comb
  begin
    unique case (slow_sel)
      2'h0: slow_div = 14'(SLOW_DIV_100K);
      2'h1: slow_div = 14'(SLOW_DIV_10K);
      2'h2: slow_div = 14'(SLOW_DIV_2K);
      2'h3: slow_div = 14'(SLOW_DIV_1K);
    endcase
  end

  assign fast_div = fast_clock_select ? 7'(FAST_DIV_LO) : 7'(FAST_DIV_HI);

  // slow prescaler, restarted when the selection changes
  always_ff @(posedge clk)
  begin
    if (!rstn || hard_clear)
    begin
      slow_pre <= 14'h0;
      slow_tick <= 1'b0;
      slow_sel_d <= 2'h0;
    end
    else
    begin
      slow_sel_d <= slow_sel;
      if (slow_sel != slow_sel_d)
      begin
        slow_pre <= 14'h0;
        slow_tick <= 1'b0;
      end
      else if (slow_pre == slow_div - 14'h1)
      begin
        slow_pre <= 14'h0;
        slow_tick <= 1'b1;
      end
      else
      begin
        slow_pre <= slow_pre + 14'h1;
        slow_tick <= 1'b0;
      end
    end
  end

  // fast prescaler
  always_ff @(posedge clk)
  begin
    if (!rstn || hard_clear)
    begin
      fast_pre <= 7'h0;
      fast_tick <= 1'b0;
      fast_clock_select_d <= 1'b0;
    end
    else
    begin
      fast_clock_select_d <= fast_clock_select;
      if (fast_clock_select != fast_clock_select_d)
      begin
        fast_pre <= 7'h0;
        fast_tick <= 1'b0;
      end
      else if (fast_pre == fast_div - 7'h1)
      begin
        fast_pre <= 7'h0;
        fast_tick <= 1'b1;
      end
      else
      begin
        fast_pre <= fast_pre + 7'h1;
        fast_tick <= 1'b0;
      end
    end
  end

  // run flag gates the free-running tick
  emt_counter #(.WIDTH(8)) u_slow (
    .clk(clk),
    .rstn(rstn),
    .hard_clear(hard_clear),
    .clear(slow_timer_clear),
    .step(slow_tick && slow_timer_run),
    .limit(interval_limit),
    .count(interval_count),
    .match(slow_irq)
  );

  emt_counter #(.WIDTH(8)) u_fast (
    .clk(clk),
    .rstn(rstn),
    .hard_clear(hard_clear),
    .clear(fast_timer_clear),
    .step(fast_tick && fast_timer_run && fast_timer_mode_select),
    .limit(fast_limit),
    .count(fast_count),
    .match(fast_irq)
  );

  // converter steering follows mode
  always_ff @(posedge clk)
  begin
    if (!rstn || hard_clear)
    begin
      dac_port_mode <= 1'b0;
      dac_force_8bit <= 1'b0;
    end
    else
    begin
      dac_port_mode <= fast_timer_mode_select;
      dac_force_8bit <= fast_timer_mode_select;
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata <= 8'h00;
    end
    else if (req.rd)
    begin
      unique case (req.addr)
        `EMT_ADDR_LIMIT: rdata <= interval_limit;
        `EMT_ADDR_COUNT: rdata <= interval_count;
        `EMT_ADDR_FAST_LIMIT: rdata <= fast_limit;
        `EMT_ADDR_SLOW_CTRL: rdata <= {4'h0, slow_timer_run, 1'b0, slow_sel};
        `EMT_ADDR_FAST_CTRL: rdata <= {4'h0, fast_timer_mode_select, 1'b0, fast_timer_run, 1'b0};
        `EMT_ADDR_FAST_CLK: rdata <= {7'h0, fast_clock_select};
        default: rdata <= 8'h00;
      endcase
    end
  end

endmodule

// >>> verification/emt_timers_assertions.sv
`timescale 1ns/1ps
module emt_timers_chk
  import emt_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic watchdog_stack_reset,
  input wire logic clock_stop,
  // bus
  input wire emt_req_t req,
  input wire logic [7:0] rdata,
  // outputs
  input wire logic slow_irq,
  input wire logic fast_irq,
  input wire logic dac_port_mode,
  input wire logic dac_force_8bit
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence mode_wr(bit m);
    req.wr && req.addr == 8'h28 && req.wdata[3] == m && !watchdog_stack_reset && !clock_stop
    ##1 !watchdog_stack_reset && !clock_stop && !(req.wr && req.addr == 8'h28);
  endsequence
  a_slow_irq_gap: assert property (slow_irq |=> !slow_irq [*3])
    else $error("slow irq too close");
  a_fast_irq_gap: assert property (fast_irq |=> !fast_irq [*7])
    else $error("fast irq too close");
  a_force_8bit_on: assert property (mode_wr(1'b1) |=> dac_force_8bit)
    else $error("8 bit force not set");
  a_force_8bit_off: assert property (mode_wr(1'b0) |=> !dac_force_8bit)
    else $error("8 bit force not cleared");
  a_mode_on_port: assert property (mode_wr(1'b1) |=> dac_port_mode)
    else $error("port mode not set");
  a_mode_off_port: assert property (mode_wr(1'b0) |=> !dac_port_mode)
    else $error("port mode not cleared");
  a_slow_clr_reads0: assert property (req.rd && req.addr == 8'h29 |=> rdata[7:4] == 4'h0 && !rdata[2])
    else $error("slow control read bad");
  a_fast_clr_reads0: assert property (req.rd && req.addr == 8'h28 |=> rdata[7:4] == 4'h0 && !rdata[2] && !rdata[0])
    else $error("fast control read bad");
  a_rdata_holds: assert property (!req.rd |=> $stable(rdata))
    else $error("rdata changed without read");
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import emt_pkg::*;
  logic clk = 0, rstn = 0, wsr = 0, cstop = 0;
  emt_req_t req = '0;
  logic [7:0] rdata, v;
  logic slow_irq, fast_irq, pm, f8;
  int n_fail = 0, checks_done = 0, lim, p;
  int div[6] = '{4, 6, 5, 10, 8, 88};
  always #50 clk = ~clk;
  emt_timers #(.SLOW_DIV_100K(4), .SLOW_DIV_10K(6), .SLOW_DIV_2K(5), .SLOW_DIV_1K(10)) emt_timers_inst (
    .clk(clk), .rstn(rstn), .watchdog_stack_reset(wsr), .clock_stop(cstop), .req(req), .rdata(rdata),
    .slow_irq(slow_irq), .fast_irq(fast_irq), .dac_port_mode(pm), .dac_force_8bit(f8));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 req = '{a, 1'b1, 1'b0, d};
    @(posedge clk) #1 req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) #1 req = '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk) #1 req.rd = 1'b0;
    v = rdata;
  endtask
  // cycles between two irq pulses
  task automatic per(input bit f, output int n);
    n = 0;
    repeat (3000) if ((f ? fast_irq : slow_irq) !== 1'b1) @(posedge clk) #1;
    do
    begin
      @(posedge clk) #1;
      n++;
    end while ((f ? fast_irq : slow_irq) !== 1'b1 && n < 3000);
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #5000000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h77ab2908));
    repeat (3) @(posedge clk);
    #1 rstn = 1;
    rd(8'h1e); chk(16'(v), 16'h00ff);
    rd(8'h1f); chk(16'(v), 16'h0000);
    for (int s = 0; s < 4; s++)
    begin
      lim = $urandom_range(8, 1);
      wr(8'h1e, lim[7:0]);
      wr(8'h29, 8'h0c | s[7:0]);
      per(0, p); chk(16'(p), 16'(lim * div[s]));
      wr(8'h29, s[7:0]);
      rd(8'h29); chk(16'(v), 16'(s));
      rd(8'h1f); lim = v;
      rd(8'h1f); chk(16'(v), 16'(lim));
      wr(8'h29, 8'h04 | s[7:0]);
      rd(8'h1f); chk(16'(v), 16'h0000);
    end
    for (int r = 0; r < 2; r++)
    begin
      wr(8'h1e, 8'h05);
      wr(8'h29, 8'h08);
      repeat (20) @(posedge clk);
      #1 {wsr, cstop} = r[0] ? 2'b01 : 2'b10;
      @(posedge clk) #1 {wsr, cstop} = 2'b00;
      rd(8'h1e); chk(16'(v), 16'h00ff);
      rd(8'h1f); chk(16'(v), 16'h0000);
      rd(8'h29); chk(16'(v), 16'h0000);
    end
    for (int f = 0; f < 2; f++)
    begin
      lim = $urandom_range(30, 1);
      wr(8'h20, lim[7:0]);
      wr(8'h2a, f[7:0]);
      wr(8'h28, 8'h08);
      wr(8'h28, 8'h0b);
      rd(8'h28); chk(16'(v), 16'h000a);
      chk(16'({pm, f8}), 16'h0003);
      per(1, p); chk(16'(p), 16'(lim * div[4 + f]));
      wr(8'h28, 8'h02);
      @(posedge clk) #1 chk(16'({pm, f8}), 16'h0000);
    end
    stop_test();
  end
endmodule
bind emt_timers emt_timers_chk emt_timers_chk_inst (.clk(clk), .rstn(rstn),
  .watchdog_stack_reset(watchdog_stack_reset), .clock_stop(clock_stop), .req(req), .rdata(rdata),
  .slow_irq(slow_irq), .fast_irq(fast_irq), .dac_port_mode(dac_port_mode), .dac_force_8bit(dac_force_8bit));
